// File: logic/core_pkg.sv
// shared constants and types of the 16-bit risc core
package core_pkg;
  localparam logic [3:0] PC_IDX = 4'h0;
  localparam logic [3:0] SP_IDX = 4'h1;
  localparam logic [3:0] SR_IDX = 4'h2;
  localparam logic [3:0] CG_IDX = 4'h3;
  localparam int SR_CARRY = 0;
  localparam int SR_ZERO = 1;
  localparam int SR_NEG = 2;
  localparam int SR_GIE = 3;
  localparam int SR_HALT = 4;
  localparam int SR_XTAL_STOP = 5;
  localparam int SR_CG_LO = 6;
  localparam int SR_CG_HI = 7;
  localparam int SR_OVF = 8;
  localparam logic [15:0] SR_MASK = 16'h01ff;
  localparam logic [15:0] SR_RESET = 16'h0000;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] CG_ZERO = 16'h0000;
  localparam logic [15:0] CG_ONE = 16'h0001;
  localparam logic [15:0] CG_TWO = 16'h0002;
  localparam logic [15:0] CG_FOUR = 16'h0004;
  localparam logic [15:0] CG_EIGHT = 16'h0008;
  localparam logic [15:0] CG_ALL = 16'hffff;
  localparam logic [1:0] AM_REG = 2'h0;
  localparam logic [1:0] AM_IDX = 2'h1;
  localparam logic [1:0] AM_IND = 2'h2;
  localparam logic [1:0] AM_INC = 2'h3;
  localparam logic [2:0] JUMP_TAG = 3'h1;
  localparam logic [5:0] SINGLE_TAG = 6'h04;
  localparam logic [3:0] OP_MOV = 4'h4;
  localparam logic [3:0] OP_ADD = 4'h5;
  localparam logic [3:0] OP_ADDC = 4'h6;
  localparam logic [3:0] OP_SUBC = 4'h7;
  localparam logic [3:0] OP_SUB = 4'h8;
  localparam logic [3:0] OP_CMP = 4'h9;
  localparam logic [3:0] OP_DADD = 4'ha;
  localparam logic [3:0] OP_BIT = 4'hb;
  localparam logic [3:0] OP_BIC = 4'hc;
  localparam logic [3:0] OP_BIS = 4'hd;
  localparam logic [3:0] OP_XOR = 4'he;
  localparam logic [3:0] OP_AND = 4'hf;
  localparam logic [2:0] SOP_RRC = 3'h0;
  localparam logic [2:0] SOP_SWAP = 3'h1;
  localparam logic [2:0] SOP_RRA = 3'h2;
  localparam logic [2:0] SOP_SXT = 3'h3;
  localparam logic [2:0] SOP_PUSH = 3'h4;
  localparam logic [2:0] SOP_CALL = 3'h5;
  localparam logic [2:0] JC_NE = 3'h0;
  localparam logic [2:0] JC_EQ = 3'h1;
  localparam logic [2:0] JC_NC = 3'h2;
  localparam logic [2:0] JC_C = 3'h3;
  localparam logic [2:0] JC_N = 3'h4;
  localparam logic [2:0] JC_GE = 3'h5;
  localparam logic [2:0] JC_L = 3'h6;
  typedef enum logic [2:0] {
    S_VEC, S_VEC_WAIT, S_FETCH, S_IR, S_SEXT, S_SDATA, S_DEXT, S_DDATA
  } state_t;
endpackage

// File: logic/core_alu.sv
// arithmetic and logic unit of the risc core
`timescale 1ns/1ps
module core_alu (
  input wire logic single, // single-operand format
  input wire logic [3:0] op, // dual opcode, or single code in low bits
  input wire logic byte_op, // byte width
  input wire logic [15:0] src, // source operand
  input wire logic [15:0] dst, // destination operand
  input wire logic [3:0] flags_in, // {v, n, z, c}
  output logic [15:0] res, // result
  output logic [3:0] flags_out, // {v, n, z, c}
  output logic res_we, // result is written back
  output logic flag_we // flags are updated
);
  import core_pkg::*;

  always_comb begin
    logic [16:0] sum;
    logic [15:0] addend;
    logic [4:0] dig;
    logic cin;
    logic cout;
    logic cbyte;
    logic dc;
    logic vflag;
    logic cnz;
    logic zf;
    logic nf;
    sum = 17'h00000;
    addend = src;
    dig = 5'h00;
    cin = 1'b0;
    cout = 1'b0;
    cbyte = 1'b0;
    dc = flags_in[0];
    vflag = 1'b0;
    cnz = 1'b0;
    zf = 1'b0;
    nf = 1'b0;
    res = dst;
    res_we = 1'b1;
    flag_we = 1'b1;
    if (single) begin
      case (op[2:0])
        SOP_RRC: begin
          res = byte_op ? {8'h00, flags_in[0], dst[7:1]} : {flags_in[0], dst[15:1]};
          cout = dst[0];
        end
        SOP_RRA: begin
          res = byte_op ? {8'h00, dst[7], dst[7:1]} : {dst[15], dst[15:1]};
          cout = dst[0];
        end
        SOP_SWAP: begin
          res = {dst[7:0], dst[15:8]};
          flag_we = 1'b0;
        end
        SOP_SXT: begin
          res = {{8{dst[7]}}, dst[7:0]};
          cnz = 1'b1;
        end
        default: begin
          res_we = 1'b0;
          flag_we = 1'b0;
        end
      endcase
    end else begin
      case (op)
        OP_MOV: begin
          res = src;
          flag_we = 1'b0;
        end
        OP_ADD, OP_ADDC, OP_SUBC, OP_SUB, OP_CMP: begin
          if (op >= OP_SUBC) begin
            addend = ~src;
          end
          cin = (op == OP_ADDC || op == OP_SUBC) ? flags_in[0] : (op >= OP_SUB);
          sum = {1'b0, dst} + {1'b0, addend} + {16'h0000, cin};
          res = sum[15:0];
          cbyte = dst[8] ^ addend[8] ^ sum[8];
          cout = byte_op ? cbyte : sum[16];
          vflag = byte_op ? (addend[7] == dst[7] && res[7] != dst[7]) :
                            (addend[15] == dst[15] && res[15] != dst[15]);
          res_we = (op != OP_CMP);
        end
        OP_DADD: begin
          for (int i = 0; i < 4; i++) begin
            dig = {1'b0, dst[4*i +: 4]} + {1'b0, src[4*i +: 4]} + {4'h0, dc};
            if (dig > 5'h09) begin
              dig = dig + 5'h06;
            end
            res[4*i +: 4] = dig[3:0];
            dc = dig[4];
            if (i == 1) begin
              cbyte = dc;
            end
          end
          cout = byte_op ? cbyte : dc;
        end
        OP_BIT, OP_AND: begin
          res = src & dst;
          cnz = 1'b1;
          res_we = (op == OP_AND);
        end
        OP_BIC: begin
          res = dst & ~src;
          flag_we = 1'b0;
        end
        OP_BIS: begin
          res = dst | src;
          flag_we = 1'b0;
        end
        OP_XOR: begin
          res = src ^ dst;
          cnz = 1'b1;
          vflag = byte_op ? (src[7] & dst[7]) : (src[15] & dst[15]);
        end
        default: begin
          res_we = 1'b0;
          flag_we = 1'b0;
        end
      endcase
    end
    if (byte_op) begin
      res = {8'h00, res[7:0]};
    end
    zf = (res == 16'h0000);
    nf = byte_op ? res[7] : res[15];
    flags_out = {vflag, nf, zf, cnz ? ~zf : cout};
  end
endmodule

// File: logic/risc16_core.sv
// 16-bit risc core: fetch, decode, operand addressing and execution
// Operation
// - register-to-register operations execute in one clock after the opcode arrives
// - sixteen registers; r0 pc, r1 sp, r2 status, r3 constants
// - register operations with seven source and four destination modes
// - decode dual-operand, single-operand and relative-jump formats
// - dual-operand result combines source and destination (mov passes source), written to destination except for cmp and bit
// - call pushes pc onto the stack, then loads the operand into pc
// - jumps unconditional or conditional; not-equal jumps only when zero clear
// - byte bit selects byte width; swap-bytes always word
// - indexed address is extension word plus register, for source and destination
// - indirect reads memory at register value, register unchanged
// - autoincrement reads at register, then adds two for words
// - immediate takes the constant following the opcode as source
// - memory and peripherals both sit on the same data, address and control bus
// - status holds v at bit 8 down to carry at bit 0; reset zero
`timescale 1ns/1ps
module risc16_core (
  input wire logic CLK, // system clock
  input wire logic ARST_N, // asynchronous reset, active low
  output logic [15:0] MEM_ADDR, // byte address
  output logic [15:0] MEM_WDATA, // write data, byte in low bits
  output logic MEM_RD, // read strobe, one cycle
  output logic MEM_WR, // write strobe, one cycle
  output logic MEM_BYTE, // byte access
  input wire logic [15:0] MEM_RDATA, // read data, valid while MEM_RD stands
  output logic INSTR_DONE, // pulse as an instruction retires
  output logic CORE_HALT, // status core halt bit
  output logic CRYSTAL_STOP, // status crystal stop bit
  output logic CLOCK_GEN_DISABLE_LO, // status clock generator disable, low
  output logic CLOCK_GEN_DISABLE_HI, // status clock generator disable, high
  output logic GLOBAL_IRQ_ENABLE // status global interrupt enable bit
);
  import core_pkg::*;

  typedef struct packed {
    state_t state;
    logic [15:0][15:0] rf;
    logic [15:0] ir;
    logic [15:0] src;
    logic [15:0] base;
    logic [15:0] dst_addr;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic mem_rd;
    logic mem_wr;
    logic mem_byte;
    logic done;
  } core_t;

  core_t r;
  core_t next_r;

  logic [15:0] iw;
  logic is_jump;
  logic is_single;
  logic is_dual;
  logic illegal;
  logic [3:0] sreg;
  logic [3:0] dreg;
  logic [1:0] am;
  logic [2:0] sop;
  logic bw;
  logic [16:0] cg;
  logic [15:0] sv;
  logic [15:0] dv;
  logic [15:0] alu_res;
  logic [3:0] alu_flags;
  logic alu_res_we;
  logic alu_flag_we;

  // returns {hit, value}; r3 always, r2 only in the two indirect encodings
  function automatic logic [16:0] const_gen(input logic [3:0] rsel, input logic [1:0] m);
    const_gen = {1'b0, CG_ZERO};
    if (rsel == CG_IDX) begin
      case (m)
        AM_REG: const_gen = {1'b1, CG_ZERO};
        AM_IDX: const_gen = {1'b1, CG_ONE};
        AM_IND: const_gen = {1'b1, CG_TWO};
        default: const_gen = {1'b1, CG_ALL};
      endcase
    end else if (rsel == SR_IDX && m[1]) begin
      const_gen = {1'b1, m[0] ? CG_EIGHT : CG_FOUR};
    end
  endfunction

  function automatic logic [15:0] width_mask(input logic b, input logic [15:0] v);
    width_mask = b ? {8'h00, v[7:0]} : v;
  endfunction

  // r3 has no storage; r2 reads zero as an index base, giving absolute mode
  function automatic logic [15:0] base_of(input core_t c, input logic [3:0] idx);
    base_of = (idx == SR_IDX || idx == CG_IDX) ? 16'h0000 : c.rf[idx];
  endfunction

  // decode straight from the bus in the opcode cycle so register ops need no extra cycle
  always_comb begin
    iw = (r.state == S_IR) ? MEM_RDATA : r.ir;
    is_jump = (iw[15:13] == JUMP_TAG);
    is_single = (iw[15:10] == SINGLE_TAG);
    is_dual = (iw[15:14] != 2'b00);
    sop = iw[9:7];
    illegal = !is_jump && !is_dual && !(is_single && sop <= SOP_CALL);
    sreg = is_dual ? iw[11:8] : iw[3:0];
    dreg = iw[3:0];
    am = iw[5:4];
    bw = iw[6] && !(is_single && (sop == SOP_SWAP || sop == SOP_SXT || sop == SOP_CALL));
    cg = const_gen(sreg, am);
  end

  // operand select kept apart from the sequencer so alu outputs never loop back
  always_comb begin
    case (r.state)
      S_IR: begin
        sv = cg[16] ? cg[15:0] : width_mask(bw, r.rf[sreg]);
        dv = is_single ? sv : width_mask(bw, r.rf[dreg]);
      end
      S_SDATA: begin
        sv = width_mask(bw, MEM_RDATA);
        dv = is_single ? sv : width_mask(bw, r.rf[dreg]);
      end
      S_DDATA: begin
        sv = r.src;
        dv = width_mask(bw, MEM_RDATA);
      end
      default: begin
        sv = r.src;
        dv = 16'h0000;
      end
    endcase
  end

  core_alu u_alu (
    .single(is_single),
    .op(is_single ? {1'b0, sop} : iw[15:12]),
    .byte_op(bw),
    .src(sv),
    .dst(dv),
    .flags_in({r.rf[SR_IDX][SR_OVF], r.rf[SR_IDX][SR_NEG], r.rf[SR_IDX][SR_ZERO],
               r.rf[SR_IDX][SR_CARRY]}),
    .res(alu_res),
    .flags_out(alu_flags),
    .res_we(alu_res_we),
    .flag_we(alu_flag_we)
  );

  always_comb begin
    logic src_ok;
    logic exec;
    logic ex_mem;
    logic taken;
    logic [15:0] addr;
    logic [15:0] sp_dec;
    src_ok = 1'b0;
    exec = 1'b0;
    ex_mem = 1'b0;
    taken = 1'b0;
    addr = 16'h0000;
    sp_dec = r.rf[SP_IDX] - WORD_STEP;
    next_r = r;
    next_r.mem_rd = 1'b0;
    next_r.mem_wr = 1'b0;
    next_r.done = 1'b0;
    case (r.state)
      S_VEC: begin
        next_r.mem_rd = 1'b1;
        next_r.mem_addr = RESET_VECTOR;
        next_r.mem_byte = 1'b0;
        next_r.state = S_VEC_WAIT;
      end
      S_VEC_WAIT: begin
        next_r.rf[PC_IDX] = MEM_RDATA;
        next_r.state = S_FETCH;
      end
      S_FETCH: begin
        // a halted core stops fetching; only reset restarts it here
        if (!r.rf[SR_IDX][SR_HALT]) begin
          next_r.mem_rd = 1'b1;
          next_r.mem_addr = r.rf[PC_IDX];
          next_r.mem_byte = 1'b0;
          next_r.rf[PC_IDX] = r.rf[PC_IDX] + WORD_STEP;
          next_r.state = S_IR;
        end
      end
      S_IR: begin
        next_r.ir = iw;
        next_r.state = S_FETCH;
        if (is_jump) begin
          case (iw[12:10])
            JC_NE: taken = !r.rf[SR_IDX][SR_ZERO];
            JC_EQ: taken = r.rf[SR_IDX][SR_ZERO];
            JC_NC: taken = !r.rf[SR_IDX][SR_CARRY];
            JC_C: taken = r.rf[SR_IDX][SR_CARRY];
            JC_N: taken = r.rf[SR_IDX][SR_NEG];
            JC_GE: taken = !(r.rf[SR_IDX][SR_NEG] ^ r.rf[SR_IDX][SR_OVF]);
            JC_L: taken = r.rf[SR_IDX][SR_NEG] ^ r.rf[SR_IDX][SR_OVF];
            default: taken = 1'b1;
          endcase
          if (taken) begin
            next_r.rf[PC_IDX] = r.rf[PC_IDX] + {{5{iw[9]}}, iw[9:0], 1'b0};
          end
          next_r.done = 1'b1;
        end else if (illegal) begin
          // unknown encodings retire as no-ops so the core cannot wedge
          next_r.done = 1'b1;
        end else if (cg[16] || am == AM_REG) begin
          src_ok = 1'b1;
        end else if (am == AM_IDX) begin
          next_r.base = base_of(r, sreg);
          next_r.mem_rd = 1'b1;
          next_r.mem_addr = r.rf[PC_IDX];
          next_r.mem_byte = 1'b0;
          next_r.rf[PC_IDX] = r.rf[PC_IDX] + WORD_STEP;
          next_r.state = S_SEXT;
        end else begin
          next_r.mem_rd = 1'b1;
          next_r.mem_addr = r.rf[sreg];
          next_r.mem_byte = bw;
          next_r.dst_addr = r.rf[sreg];
          if (am == AM_INC) begin
            // pc and sp stay word aligned even for byte operands
            next_r.rf[sreg] = r.rf[sreg] +
              ((bw && sreg != PC_IDX && sreg != SP_IDX) ? BYTE_STEP : WORD_STEP);
          end
          next_r.state = S_SDATA;
        end
      end
      S_SEXT: begin
        addr = MEM_RDATA + r.base;
        next_r.dst_addr = addr;
        next_r.mem_rd = 1'b1;
        next_r.mem_addr = addr;
        next_r.mem_byte = bw;
        next_r.state = S_SDATA;
      end
      S_SDATA: begin
        src_ok = 1'b1;
      end
      S_DEXT: begin
        addr = MEM_RDATA + r.base;
        next_r.dst_addr = addr;
        if (iw[15:12] == OP_MOV) begin
          // a move never needs the old destination, so skip its read
          exec = 1'b1;
          ex_mem = 1'b1;
        end else begin
          next_r.mem_rd = 1'b1;
          next_r.mem_addr = addr;
          next_r.mem_byte = bw;
          next_r.state = S_DDATA;
        end
      end
      S_DDATA: begin
        exec = 1'b1;
        ex_mem = 1'b1;
      end
      default: begin
        next_r.state = S_VEC;
      end
    endcase

    if (src_ok) begin
      next_r.src = sv;
      next_r.state = S_FETCH;
      if (is_single && (sop == SOP_PUSH || sop == SOP_CALL)) begin
        next_r.rf[SP_IDX] = sp_dec;
        next_r.mem_wr = 1'b1;
        next_r.mem_addr = sp_dec;
        next_r.mem_byte = bw;
        next_r.mem_wdata = (sop == SOP_CALL) ? r.rf[PC_IDX] : sv;
        if (sop == SOP_CALL) begin
          next_r.rf[PC_IDX] = sv;
        end
        next_r.done = 1'b1;
      end else if (is_single) begin
        exec = 1'b1;
        ex_mem = (r.state == S_SDATA);
      end else if (!iw[7]) begin
        exec = 1'b1;
      end else begin
        // one destination mode bit: register, or indexed/symbolic/absolute
        next_r.base = base_of(r, dreg);
        next_r.mem_rd = 1'b1;
        next_r.mem_addr = r.rf[PC_IDX];
        next_r.mem_byte = 1'b0;
        next_r.rf[PC_IDX] = r.rf[PC_IDX] + WORD_STEP;
        next_r.state = S_DEXT;
      end
    end

    if (exec) begin
      next_r.state = S_FETCH;
      next_r.done = 1'b1;
      if (alu_res_we) begin
        if (ex_mem) begin
          next_r.mem_wr = 1'b1;
          next_r.mem_addr = next_r.dst_addr;
          next_r.mem_byte = bw;
          next_r.mem_wdata = alu_res;
        end else if (dreg == SR_IDX) begin
          next_r.rf[SR_IDX] = alu_res & SR_MASK;
        end else if (dreg != CG_IDX) begin
          next_r.rf[dreg] = alu_res;
        end
      end
      // an explicit write to the status register beats the flag update
      if (alu_flag_we && !(alu_res_we && !ex_mem && dreg == SR_IDX)) begin
        next_r.rf[SR_IDX][SR_CARRY] = alu_flags[0];
        next_r.rf[SR_IDX][SR_ZERO] = alu_flags[1];
        next_r.rf[SR_IDX][SR_NEG] = alu_flags[2];
        next_r.rf[SR_IDX][SR_OVF] = alu_flags[3];
      end
    end
    next_r.rf[CG_IDX] = 16'h0000;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= '0;
      r.state <= S_VEC;
      r.rf[SR_IDX] <= SR_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign MEM_ADDR = r.mem_addr;
  assign MEM_WDATA = r.mem_wdata;
  assign MEM_RD = r.mem_rd;
  assign MEM_WR = r.mem_wr;
  assign MEM_BYTE = r.mem_byte;
  assign INSTR_DONE = r.done;
  assign CORE_HALT = r.rf[SR_IDX][SR_HALT];
  assign CRYSTAL_STOP = r.rf[SR_IDX][SR_XTAL_STOP];
  assign CLOCK_GEN_DISABLE_LO = r.rf[SR_IDX][SR_CG_LO];
  assign CLOCK_GEN_DISABLE_HI = r.rf[SR_IDX][SR_CG_HI];
  assign GLOBAL_IRQ_ENABLE = r.rf[SR_IDX][SR_GIE];
endmodule

// File: dv/risc16_core_chk.sv
// concurrent checks on the core's memory bus and status outputs
`timescale 1ns/1ps
module risc16_core_chk (
  input wire logic CLK, // system clock
  input wire logic ARST_N, // async reset, active low
  input wire logic [15:0] MEM_ADDR, // byte address
  input wire logic [15:0] MEM_WDATA, // write data
  input wire logic MEM_RD, // read strobe
  input wire logic MEM_WR, // write strobe
  input wire logic MEM_BYTE, // byte access
  input wire logic [15:0] MEM_RDATA, // read data
  input wire logic INSTR_DONE, // retire pulse
  input wire logic CORE_HALT, // status halt
  input wire logic CRYSTAL_STOP, // status crystal stop
  input wire logic CLOCK_GEN_DISABLE_LO, // status clock disable low
  input wire logic CLOCK_GEN_DISABLE_HI, // status clock disable high
  input wire logic GLOBAL_IRQ_ENABLE // status interrupt enable
);
  import core_pkg::*;
  logic [15:0] last_rd_addr;
  logic [4:0] status;
  assign status = {CORE_HALT, CRYSTAL_STOP, CLOCK_GEN_DISABLE_LO, CLOCK_GEN_DISABLE_HI,
    GLOBAL_IRQ_ENABLE};
  // a push is tied to the fetch that brought the call in
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      last_rd_addr <= 16'h0000;
    end else if (MEM_RD) begin
      last_rd_addr <= MEM_ADDR;
    end
  end
  // any read arms this, so bench data must never look like a register op
  function automatic logic is_rr(logic [15:0] w);
    return w[15:12] >= OP_MOV && !w[7] && w[5:4] == AM_REG && w[3:0] != PC_IDX;
  endfunction
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  property p_rr_one_cycle;
    MEM_RD && is_rr(MEM_RDATA) |=> INSTR_DONE;
  endproperty
  a_rr_one_cycle: assert property (p_rr_one_cycle) else $error("slow register op");
  property p_vector;
    $rose(ARST_N) |=> MEM_RD && MEM_ADDR == RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector read");
  property p_status_reset;
    $rose(ARST_N) |-> status == 5'h00;
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status not reset");
  property p_no_overlap;
    !(MEM_RD && MEM_WR);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("read and write at once");
  // reads may run back to back since data is taken in the strobe cycle; a write always retires
  property p_strobe_gap;
    MEM_WR |=> MEM_RD && !MEM_WR;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("write not followed by fetch");
  property p_call_push;
    MEM_RD && MEM_RDATA[15:4] == {SINGLE_TAG, SOP_CALL, 1'b0, AM_REG}
      |=> MEM_WR && MEM_WDATA == last_rd_addr + WORD_STEP;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong");
  property p_word_even;
    (MEM_RD || MEM_WR) && !MEM_BYTE |-> !MEM_ADDR[0];
  endproperty
  a_word_even: assert property (p_word_even) else $error("odd word address");
  property p_status_after_done;
    !$stable(status) |-> INSTR_DONE;
  endproperty
  a_status_after_done: assert property (p_status_after_done) else $error("status moved");
  property p_halt_quiet;
    CORE_HALT [*4] |-> !MEM_RD && !MEM_WR;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("bus active in halt");
  c_call: cover property (MEM_RD && MEM_RDATA[15:4] == {SINGLE_TAG, SOP_CALL, 1'b0, AM_REG});
  c_byte_write: cover property (MEM_WR && MEM_BYTE);
  c_halt: cover property ($rose(CORE_HALT));
endmodule
bind risc16_core risc16_core_chk u_risc16_core_chk (.CLK(CLK), .ARST_N(ARST_N),
  .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
  .MEM_BYTE(MEM_BYTE), .MEM_RDATA(MEM_RDATA), .INSTR_DONE(INSTR_DONE), .CORE_HALT(CORE_HALT),
  .CRYSTAL_STOP(CRYSTAL_STOP), .CLOCK_GEN_DISABLE_LO(CLOCK_GEN_DISABLE_LO),
  .CLOCK_GEN_DISABLE_HI(CLOCK_GEN_DISABLE_HI), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));

// File: dv/mem_model.sv
// behavioural program and data memory on the core's bus, no wait states
`timescale 1ns/1ps
module mem_model (
  input wire logic CLK, // system clock
  input wire logic [15:0] MEM_ADDR, // byte address
  input wire logic [15:0] MEM_WDATA, // write data
  input wire logic MEM_RD, // read strobe
  input wire logic MEM_WR, // write strobe
  input wire logic MEM_BYTE, // byte access
  output logic [15:0] MEM_RDATA // read data
);
  logic [15:0] mem [0:32767];
  logic [15:0] word;
  // the core takes read data at the edge that ends its strobe, so reads answer at once
  always_comb begin
    word = mem[MEM_ADDR[15:1]];
    if (MEM_RD && MEM_BYTE) begin
      // upper lane is junk so a core that uses it gets caught
      MEM_RDATA = MEM_ADDR[0] ? {~word[15:8], word[15:8]} : {~word[7:0], word[7:0]};
    end else if (MEM_RD) begin
      MEM_RDATA = word;
    end else begin
      // no read in flight: show the inverse rather than a word that looks valid
      MEM_RDATA = ~word;
    end
  end
  always @(posedge CLK) begin
    if (MEM_WR && !MEM_BYTE) begin
      mem[MEM_ADDR[15:1]] <= MEM_WDATA;
    end else if (MEM_WR && MEM_ADDR[0]) begin
      mem[MEM_ADDR[15:1]][15:8] <= MEM_WDATA[7:0];
    end else if (MEM_WR) begin
      mem[MEM_ADDR[15:1]][7:0] <= MEM_WDATA[7:0];
    end
  end
endmodule

// File: dv/testbench.sv
// self-checking testbench: the core runs small programs from the memory model
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import core_pkg::*;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic MEM_RD, MEM_WR, MEM_BYTE, INSTR_DONE, CORE_HALT, CRYSTAL_STOP;
  logic CLOCK_GEN_DISABLE_LO, CLOCK_GEN_DISABLE_HI, GLOBAL_IRQ_ENABLE;
  int bad_count = 0;
  int checks_done = 0;
  risc16_core u_risc16_core (.CLK(CLK), .ARST_N(ARST_N), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_BYTE(MEM_BYTE),
    .MEM_RDATA(MEM_RDATA), .INSTR_DONE(INSTR_DONE), .CORE_HALT(CORE_HALT),
    .CRYSTAL_STOP(CRYSTAL_STOP), .CLOCK_GEN_DISABLE_LO(CLOCK_GEN_DISABLE_LO),
    .CLOCK_GEN_DISABLE_HI(CLOCK_GEN_DISABLE_HI), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));
  mem_model u_mem_model (.CLK(CLK), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_BYTE(MEM_BYTE), .MEM_RDATA(MEM_RDATA));
  initial begin
    forever #50 CLK = ~CLK;
  end
  function automatic logic [15:0] op2(int op, int rs, int ad, int bw, int am, int rd);
    return {4'(op), 4'(rs), 1'(ad), 1'(bw), 2'(am), 4'(rd)};
  endfunction
  function automatic logic [15:0] imm(int rd);
    return op2(OP_MOV, 0, 0, 0, 3, rd);
  endfunction
  function automatic logic [15:0] sto(int rs);
    return op2(OP_MOV, rs, 1, 0, 0, 2);
  endfunction
  function automatic logic [15:0] sg(input logic [2:0] sop, input logic [3:0] r);
    return {SINGLE_TAG, sop, 1'b0, AM_REG, r};
  endfunction
  function automatic logic [15:0] jp(input logic [2:0] c);
    return {JUMP_TAG, c, 10'h003};
  endfunction
  function automatic logic [15:0] rd_mem(input logic [15:0] a);
    return u_mem_model.mem[a[15:1]];
  endfunction
  task automatic poke(input logic [15:0] a, input logic [15:0] v);
    u_mem_model.mem[a[15:1]] = v;
  endtask
  // loads the program behind the reset vector, appends a halt, runs to halt
  task automatic run(input logic [15:0] p[$]);
    int n;
    @(posedge CLK);
    ARST_N <= 1'b0;
    p.push_back(16'hd032);
    p.push_back(16'h0010);
    foreach (p[i]) poke(16'hc000 + 16'(2 * i), p[i]);
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    n = 0;
    while (CORE_HALT !== 1'b1 && n < 400) begin
      @(posedge CLK);
      n++;
    end
    `CHK("halt reached", 1'b1, CORE_HALT)
    repeat (6) @(posedge CLK);
  endtask
  task automatic t_alu();
    logic [15:0] p[$];
    p = '{imm(4), 16'h1234, imm(5), 16'h0f0f, op2(OP_ADD, 4, 0, 0, 0, 5), sto(5), 16'h0200,
      imm(6), 16'h00ff, op2(OP_ADD, 4, 0, 1, 0, 6), sto(6), 16'h0202,
      sg(SOP_SWAP, 4), sto(4), 16'h0204};
    run(p);
    `CHK("word sum", 16'h2143, rd_mem(16'h0200))
    `CHK("byte sum", 16'h0033, rd_mem(16'h0202))
    `CHK("swapped", 16'h3412, rd_mem(16'h0204))
  endtask
  task automatic t_modes();
    logic [15:0] p[$];
    poke(16'h0210, 16'h0111);
    poke(16'h0212, 16'h0222);
    poke(16'h0220, 16'h0333);
    // last word reaches 0x020c from the extension word at 0xc022
    p = '{imm(7), 16'h020e, op2(OP_MOV, 7, 0, 0, 1, 8), 16'h0002, imm(10), 16'h0212,
      op2(OP_MOV, 10, 0, 0, 2, 11), op2(OP_MOV, 10, 0, 0, 3, 12),
      op2(OP_ADD, 11, 1, 0, 0, 7), 16'h0012, sto(8), 16'h0206, sto(12), 16'h0208,
      sto(10), 16'h020a, op2(OP_MOV, 11, 1, 0, 0, 0), 16'h41ea};
    run(p);
    `CHK("indexed source", 16'h0111, rd_mem(16'h0206))
    `CHK("autoinc data", 16'h0222, rd_mem(16'h0208))
    `CHK("autoinc pointer", 16'h0214, rd_mem(16'h020a))
    `CHK("indirect data", 16'h0222, rd_mem(16'h020c))
    `CHK("indexed dest", 16'h0555, rd_mem(16'h0220))
  endtask
  task automatic t_flow();
    logic [15:0] p[$];
    for (int i = 0; i < 4; i++) begin
      poke(16'h0210 + 16'(2 * i), 16'h0000);
    end
    poke(16'h027e, 16'h0000);
    p = '{imm(1), 16'h0280, imm(8), 16'hc010, sg(SOP_CALL, 8),
      sto(0) | 16'h0030, 16'h0099, 16'h0214, sto(1), 16'h020e,
      op2(OP_CMP, 4, 0, 0, 0, 4), jp(JC_NE), sto(0) | 16'h0030, 16'h0011, 16'h0210,
      op2(OP_CMP, 1, 0, 0, 0, 4), jp(JC_NE), sto(0) | 16'h0030, 16'h0022, 16'h0212,
      jp(3'h7), sto(0) | 16'h0030, 16'h0033, 16'h0216};
    run(p);
    `CHK("pushed pc", 16'hc00a, rd_mem(16'h027e))
    `CHK("stack after call", 16'h027e, rd_mem(16'h020e))
    `CHK("skipped by call", 16'h0000, rd_mem(16'h0214))
    `CHK("equal not taken", 16'h0011, rd_mem(16'h0210))
    `CHK("unequal taken", 16'h0000, rd_mem(16'h0212))
    `CHK("always taken", 16'h0000, rd_mem(16'h0216))
  endtask
  task automatic t_status();
    logic [15:0] p[$];
    logic [4:0] st;
    poke(16'h021a, 16'h1111);
    p = '{imm(2), 16'hffef, sto(2), 16'h0218, op2(OP_MOV, 0, 1, 1, 3, 2), 16'h0055, 16'h021b};
    run(p);
    st = {CORE_HALT, CRYSTAL_STOP, CLOCK_GEN_DISABLE_LO, CLOCK_GEN_DISABLE_HI, GLOBAL_IRQ_ENABLE};
    `CHK("status word", 16'h01ef, rd_mem(16'h0218))
    `CHK("status pins", 5'h1f, st)
    `CHK("byte store", 16'h5511, rd_mem(16'h021a))
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 32768; i++) begin
      u_mem_model.mem[i] = 16'h0000;
    end
    u_mem_model.mem[15'h7fff] = 16'hc000;
    t_alu();
    t_modes();
    t_flow();
    t_status();
    report_and_stop();
  end
  initial begin
    repeat (4000) @(posedge CLK);
    bad_count++;
    report_and_stop();
  end
endmodule
